// ---- logic/gpwm_top.sv ----
// Purpose: pin level pwm encoder for pins 0 and 1 with apb registers
// Assumes: apb master keeps psel/paddr/pwrite/pwdata stable in access
// Notes:   zero wait states; unmapped addresses read zero, pslverr high
//
// Behaviour
// - period is high plus low counts times unit
// - output high for high count units
// - output low for low count units
// - separate counter pair per output level
// - zero high count gives static low
// - zero low count, nonzero high: static high
// - both counts zero gives static low
// - pin1 low-level pair resets static low
// - pin1 high-level pair resets static high
// - pin0 high-level pair, reset all-ones/zero
// - time base 16/64/256/1024 clock periods
// - output data bit picks the level
//
// Added by the designer: the APB slave port.
`timescale 1ns/100ps
`include "gpwm_defs.svh"

module gpwm_top
    import gpwm_pkg::*;
(
    input  wire logic        clk,        // 25 MHz master clock
    input  wire logic        rstn,       // sync reset, active low
    input  wire logic        ce,         // clock enable, freezes all
    input  wire logic        psel,       // apb select
    input  wire logic        penable,    // apb access phase
    input  wire logic        pwrite,     // apb direction
    input  wire logic [11:0] paddr,      // apb byte address
    input  wire logic [31:0] pwdata,     // apb write data
    input  wire logic [3:0]  pstrb,      // apb byte strobes
    output logic      [31:0] prdata,     // apb read data
    output logic             pready,     // apb ready
    output logic             pslverr,    // apb error
    output logic             general_pin_zero, // encoded pin 0
    output logic             general_pin_one   // encoded pin 1
);
    import gpwm_pkg::*;

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    logic [15:0] p0_ll;                  // pin 0 low level pair
    logic [15:0] p0_lh;                  // pin 0 high level pair
    logic [15:0] p1_ll;                  // pin 1 low level pair
    logic [15:0] p1_lh;                  // pin 1 high level pair
    logic [1:0]  out_data;               // output data bits

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    wire [9:0] idx      = paddr[11:2];   // word index
    wire       acc      = psel && penable && ce;
    wire       wr       = acc && pwrite;
    wire       hit_p0ll = (idx == {2'b00, `GPWM_IDX_P0_LL});
    wire       hit_p0lh = (idx == {2'b00, `GPWM_IDX_P0_LH});
    wire       hit_p1ll = (idx == {2'b00, `GPWM_IDX_P1_LL});
    wire       hit_p1lh = (idx == {2'b00, `GPWM_IDX_P1_LH});
    wire       hit_dat  = (idx == {2'b00, `GPWM_IDX_OUT_DATA});
    wire       hit_sts  = (idx == {2'b00, `GPWM_IDX_STATUS});
    wire       hit_any  = hit_p0ll | hit_p0lh | hit_p1ll | hit_p1lh |
                          hit_dat | hit_sts;
    // byte lane merge for a 16-bit register
    wire [15:0] wmask   = {{8{pstrb[1]}}, {8{pstrb[0]}}};

    // single-cycle access phase, no wait states
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit_any;

    // ----------------------------------------------------------------
    // register writes; reserved bits of high level pairs stay zero
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            p0_ll    <= `GPWM_RST_LL;
            p0_lh    <= `GPWM_RST_LH;
            p1_ll    <= `GPWM_RST_LL;
            p1_lh    <= `GPWM_RST_LH;
            out_data <= 2'h0;
        end
        else if (wr)
        begin
            if (hit_p0ll)
                p0_ll <= (p0_ll & ~wmask) | (pwdata[15:0] & wmask);
            if (hit_p0lh)
                p0_lh <= ((p0_lh & ~wmask) | (pwdata[15:0] & wmask))
                         & `GPWM_LH_WMASK;
            if (hit_p1ll)
                p1_ll <= (p1_ll & ~wmask) | (pwdata[15:0] & wmask);
            if (hit_p1lh)
                p1_lh <= ((p1_lh & ~wmask) | (pwdata[15:0] & wmask))
                         & `GPWM_LH_WMASK;
            if (hit_dat && pstrb[0])
                out_data <= pwdata[1:0];
        end
    end

    // ----------------------------------------------------------------
    // read mux, registered
    // ----------------------------------------------------------------
    logic pin0_level;                    // pair in use, pin 0
    logic pin1_level;                    // pair in use, pin 1
    logic [31:0] next_prdata;            // read value

    always_comb
    begin
        next_prdata = 32'h0000_0000;
        if (hit_p0ll) next_prdata = {16'h0000, p0_ll};
        if (hit_p0lh) next_prdata = {16'h0000, p0_lh};
        if (hit_p1ll) next_prdata = {16'h0000, p1_ll};
        if (hit_p1lh) next_prdata = {16'h0000, p1_lh};
        if (hit_dat)  next_prdata = {30'h0, out_data};
        if (hit_sts)  next_prdata = {28'h0, pin1_level, pin0_level,
                                     general_pin_one, general_pin_zero};
    end

    // data captured in setup so it is valid through the access phase
    always_ff @(posedge clk)
    begin
        if (!rstn)
            prdata <= 32'h0000_0000;
        else if (ce && psel && !penable && !pwrite)
            prdata <= next_prdata;
    end

    // ----------------------------------------------------------------
    // pin engines; each pin's time base lives in its low level pair
    // ----------------------------------------------------------------
    wire pin0_output_value = out_data[0];
    wire pin1_output_value = out_data[1];

    gpwm_channel u_pin0
    (
        .clk       (clk),
        .rstn      (rstn),
        .ce        (ce),
        .tb_sel    (p0_ll[`GPWM_TB_HI:`GPWM_TB_LO]),
        .level     (pin0_output_value),
        .ll_hc     (p0_ll[`GPWM_HC_HI:`GPWM_HC_LO]),
        .ll_lc     (p0_ll[`GPWM_LC_HI:`GPWM_LC_LO]),
        .lh_hc     (p0_lh[`GPWM_HC_HI:`GPWM_HC_LO]),
        .lh_lc     (p0_lh[`GPWM_LC_HI:`GPWM_LC_LO]),
        .pin_out   (general_pin_zero),
        .cur_level (pin0_level)
    );

    gpwm_channel u_pin1
    (
        .clk       (clk),
        .rstn      (rstn),
        .ce        (ce),
        .tb_sel    (p1_ll[`GPWM_TB_HI:`GPWM_TB_LO]),
        .level     (pin1_output_value),
        .ll_hc     (p1_ll[`GPWM_HC_HI:`GPWM_HC_LO]),
        .ll_lc     (p1_ll[`GPWM_LC_HI:`GPWM_LC_LO]),
        .lh_hc     (p1_lh[`GPWM_HC_HI:`GPWM_HC_LO]),
        .lh_lc     (p1_lh[`GPWM_LC_HI:`GPWM_LC_LO]),
        .pin_out   (general_pin_one),
        .cur_level (pin1_level)
    );
endmodule // gpwm_top

// ---- logic/gpwm_defs.svh ----
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 32-bit APB, one register per aligned word
// Notes:   printed offsets are indices; byte address is four times
`ifndef GPWM_DEFS_SVH
`define GPWM_DEFS_SVH

// ----------------------------------------------------------------
// register indices and index width
// ----------------------------------------------------------------
`define GPWM_IDX_P0_LL      8'h4F
`define GPWM_IDX_P0_LH      8'h50
`define GPWM_IDX_P1_LL      8'h51
`define GPWM_IDX_P1_LH      8'h52
`define GPWM_IDX_OUT_DATA   8'h60
`define GPWM_IDX_STATUS     8'h61
`define GPWM_ADDR_W         10

// ----------------------------------------------------------------
// field layout
// ----------------------------------------------------------------
`define GPWM_TB_HI          15
`define GPWM_TB_LO          14
`define GPWM_HC_HI          13
`define GPWM_HC_LO          7
`define GPWM_LC_HI          6
`define GPWM_LC_LO          0
`define GPWM_CNT_W          7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define GPWM_RST_LL         16'h007F
`define GPWM_RST_LH         16'h3F80
`define GPWM_LH_WMASK       16'h3FFF

// ----------------------------------------------------------------
// time base: master clock periods per unit, per select code
// ----------------------------------------------------------------
`define GPWM_TB0_CYC        11'h010
`define GPWM_TB1_CYC        11'h040
`define GPWM_TB2_CYC        11'h100
`define GPWM_TB3_CYC        11'h400
`define GPWM_TB_W           11

`endif

// ---- logic/gpwm_pkg.sv ----
// Purpose: shared types of the pin level pwm encoder
// Assumes: nothing
// Notes:   numbers live in gpwm_defs.svh
package gpwm_pkg;
    // pwm phase states, one-hot
    typedef enum logic [2:0]
    {
        GPWM_ST_STATIC = 3'b001,
        GPWM_ST_HIGH   = 3'b010,
        GPWM_ST_LOW    = 3'b100
    } gpwm_state_t;

    typedef logic [6:0] gpwm_cnt_t;   // one phase count
endpackage

// ---- logic/gpwm_channel.sv ----
// Purpose: one pin's pwm engine with two counter pairs
// Assumes: configuration stable or changing between cycles
// Notes:   pair chosen only at a cycle boundary
`timescale 1ns/100ps
`include "gpwm_defs.svh"

module gpwm_channel
    import gpwm_pkg::*;
(
    input  wire logic               clk,        // master clock
    input  wire logic               rstn,       // sync reset, low
    input  wire logic               ce,         // clock enable
    input  wire logic [1:0]         tb_sel,     // time base code
    input  wire logic               level,      // selected level
    input  wire gpwm_pkg::gpwm_cnt_t ll_hc,     // low level high count
    input  wire gpwm_pkg::gpwm_cnt_t ll_lc,     // low level low count
    input  wire gpwm_pkg::gpwm_cnt_t lh_hc,     // high level high count
    input  wire gpwm_pkg::gpwm_cnt_t lh_lc,     // high level low count
    output logic                    pin_out,    // encoded pin
    output logic                    cur_level   // level in use
);
    import gpwm_pkg::*;

    // ----------------------------------------------------------------
    // time base prescaler
    // ----------------------------------------------------------------
    logic [`GPWM_TB_W-1:0] pre;          // prescale counter
    logic [`GPWM_TB_W-1:0] tb_len;       // unit length in cycles
    wire                   tick;         // end of one unit
    wire                   restart;      // cycle opens out of static

    always_comb
    begin
        case (tb_sel)
            2'h0:    tb_len = `GPWM_TB0_CYC;
            2'h1:    tb_len = `GPWM_TB1_CYC;
            2'h2:    tb_len = `GPWM_TB2_CYC;
            default: tb_len = `GPWM_TB3_CYC;
        endcase
    end

    // >= guards a shrinking time base mid unit
    assign tick = (pre >= tb_len - 11'h001);

    // unit counter; restarted when a cycle opens from static so the
    // first high phase is a whole number of units, not a fragment
    always_ff @(posedge clk)
    begin
        if (!rstn)
            pre <= '0;
        else if (ce)
            pre <= (tick || restart) ? '0 : pre + 11'h001;
    end

    // ----------------------------------------------------------------
    // pair selection and phase machine
    // ----------------------------------------------------------------
    gpwm_state_t state;                  // current phase
    gpwm_state_t next_state;             // next phase
    gpwm_cnt_t   units;                  // units left in phase
    gpwm_cnt_t   next_units;             // next units left
    logic        next_level;             // pair taken at boundary
    wire gpwm_cnt_t sel_hc = level ? lh_hc : ll_hc;
    wire gpwm_cnt_t sel_lc = level ? lh_lc : ll_lc;
    wire         boundary;               // new cycle may start
    wire         phase_end;              // last unit of phase

    assign phase_end = tick && (units <= 7'h01);
    assign boundary  = (state == GPWM_ST_STATIC) ||
                       (state == GPWM_ST_LOW && phase_end);
    assign restart   = (state == GPWM_ST_STATIC) &&
                       (next_state == GPWM_ST_HIGH);

    // next phase; a fresh cycle opens high, then low
    always_comb
    begin
        next_state = state;
        next_units = units;
        next_level = cur_level;
        case (state)
            GPWM_ST_HIGH:
            begin
                if (tick)
                    next_units = units - 7'h01;
                if (phase_end)
                begin
                    next_state = GPWM_ST_LOW;
                    next_units = cur_level ? lh_lc : ll_lc;
                end
            end
            GPWM_ST_LOW, GPWM_ST_STATIC:
            begin
                if (tick && state == GPWM_ST_LOW)
                    next_units = units - 7'h01;
                if (boundary)
                begin
                    next_level = level;
                    if (sel_hc == 7'h00 || sel_lc == 7'h00)
                        next_state = GPWM_ST_STATIC;
                    else
                    begin
                        next_state = GPWM_ST_HIGH;
                        next_units = sel_hc;
                    end
                end
            end
            default:
                next_state = GPWM_ST_STATIC;
        endcase
    end

    // phase registers
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            state     <= GPWM_ST_STATIC;
            units     <= '0;
            cur_level <= 1'b0;
        end
        else if (ce)
        begin
            state     <= next_state;
            units     <= next_units;
            cur_level <= next_level;
        end
    end

    // ----------------------------------------------------------------
    // output; static high only with nonzero high and zero low count
    // ----------------------------------------------------------------
    wire static_hi = (next_state == GPWM_ST_STATIC) &&
                     (sel_hc != 7'h00) && (sel_lc == 7'h00);

    // registered pin, period = (hc + lc) units
    always_ff @(posedge clk)
    begin
        if (!rstn)
            pin_out <= 1'b0;
        else if (ce)
            pin_out <= (next_state == GPWM_ST_HIGH) || static_hi;
    end
endmodule // gpwm_channel

// ---- verification/gpwm_chk.sv ----
// Purpose: port checks for the pin level pwm encoder
// Assumes: bench phase counts stay at 4 units or less
// Notes:   pin 1 state predicted from a shadow of apb writes
`timescale 1ns/100ps
`include "gpwm_defs.svh"

module gpwm_chk
(
    input wire logic        clk,              // master clock
    input wire logic        rstn,             // sync reset, low
    input wire logic        psel,             // apb select
    input wire logic        penable,          // apb access
    input wire logic        pwrite,           // apb direction
    input wire logic [11:0] paddr,            // apb address
    input wire logic [31:0] pwdata,           // apb write data
    input wire logic [31:0] prdata,           // apb read data
    input wire logic        pready,           // apb ready
    input wire logic        pslverr,          // apb error
    input wire logic        general_pin_zero, // pin 0
    input wire logic        general_pin_one   // pin 1
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // ------------------------------------
    // shadow of pin 1 registers
    // ------------------------------------
    logic [15:0] p1_ll;   // low level pair
    logic [15:0] p1_lh;   // high level pair
    logic        p1_dat;  // level in force
    int          qc;      // cycles since a pin 1 write
    wire         acc = psel && penable && pready;  // access edge
    wire         wr  = acc && pwrite;              // write lands
    wire         rd  = acc && !pwrite;             // read taken
    wire [9:0]   ix  = paddr[11:2];                // word index
    wire         hit = (ix >= 10'h04F && ix <= 10'h052)
                       || ix == 10'h060 || ix == 10'h061; // mapped
    wire         rll = rd && ix == 10'h051;        // pin 1 low pair
    wire         rlh = rd && ix == 10'h052;        // pin 1 high pair
    wire         rp0 = rd && ix == 10'h050;        // pin 0 high pair
    wire         pz  = general_pin_zero;           // pin 0 level
    wire         po  = general_pin_one;            // pin 1 level
    wire [6:0]   hc  = p1_dat ? p1_lh[13:7] : p1_ll[13:7]; // pair high
    wire [6:0]   lc  = p1_dat ? p1_lh[6:0] : p1_ll[6:0];   // pair low
    wire         quiet = qc > 4500;  // long enough for a pair swap at time base codes 0 to 2
    // the swap waits for a cycle end, so static checks hold off
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            p1_ll  <= `GPWM_RST_LL;
            p1_lh  <= `GPWM_RST_LH;
            p1_dat <= 1'b0;
            qc     <= 0;
        end
        else
        begin
            qc <= (qc < 9999) ? qc + 1 : qc;
            if (wr && ix == 10'h051)
                p1_ll <= pwdata[15:0];
            if (wr && ix == 10'h052)
                p1_lh <= pwdata[15:0] & `GPWM_LH_WMASK;
            if (wr && ix == 10'h060)
                p1_dat <= pwdata[1];
            if (wr && (ix == 10'h051 || ix == 10'h052 || ix == 10'h060))
                qc <= 0;
        end
    end
    property p_err; acc |-> pslverr == !hit; endproperty
    a_err: assert property (p_err) else $error("bad error flag");
    property p_ll_rd; rll |-> prdata == {16'h0000, p1_ll}; endproperty
    a_ll_rd: assert property (p_ll_rd) else $error("low pair read");
    property p_lh_rd; rlh |-> prdata == {16'h0000, p1_lh}; endproperty
    a_lh_rd: assert property (p_lh_rd) else $error("high pair read");
    property p_rsv; rp0 |-> prdata[15:14] == 2'b00; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
    property p_rst; $rose(rstn) |-> !po [*8]; endproperty
    a_rst: assert property (p_rst) else $error("pin 1 not low");
    property p_hi; $rose(po) |-> po [*8] ##1 po [*8]; endproperty
    a_hi: assert property (p_hi) else $error("high phase short");
    property p_lo; $fell(pz) |-> !pz [*8] ##1 !pz [*8]; endproperty
    a_lo: assert property (p_lo) else $error("low phase short");
    property p_slo; quiet && hc == 7'h00 |-> !po; endproperty
    a_slo: assert property (p_slo) else $error("not static low");
    property p_shi; quiet && hc != 7'h00 && lc == 7'h00 |-> po; endproperty
    a_shi: assert property (p_shi) else $error("not static high");
    c_err: cover property (acc && !hit);
    c_shi: cover property (quiet && lc == 7'h00);
    c_pwm: cover property ($fell(pz));
endmodule // gpwm_chk

// ---- verification/gpwm_rx.sv ----
// Purpose: far end receiver timing one pwm cycle on a pin
// Assumes: pin is push-pull, sampled on the master clock
// Notes:   first rise after arm skipped, that cycle may be partial
`timescale 1ns/100ps

module gpwm_rx
#(
    parameter int QUIET = 5000  // edgeless cycles meaning static
)
(
    input  wire logic        clk,  // master clock
    input  wire logic        pin,  // sensed pin
    input  wire logic        arm,  // start one measurement
    output logic             done, // result strobe
    output logic [32:0]      res   // level, high width, low width
);
    logic prev = 1'b0;         // pin one cycle back
    int   ph   = 0;            // 0 idle 1 skip 2 wait 3 high 4 low
    int   q    = 0;            // cycles since last edge
    wire  rise = pin && !prev; // rising edge seen
    wire  fall = !pin && prev; // falling edge seen
    // ------------------------------------
    // edge timing
    // ------------------------------------
    always @(posedge clk)
    begin
        done <= 1'b0;
        prev <= pin;
        q    <= (rise || fall) ? 0 : q + 1;
        if (arm)
        begin
            ph  <= 1;
            q   <= 0;
            res <= '0;
        end
        else if (ph != 0 && q >= QUIET)
        begin
            ph   <= 0;  // no edges: level is static
            done <= 1'b1;
            res  <= {pin, 32'h0};
        end
        else if (rise && ph == 4)
        begin
            ph      <= 0;  // next cycle starts: report
            done    <= 1'b1;
            res[32] <= 1'b1;
        end
        else if (rise && ph > 0 && ph < 3)
        begin
            ph         <= ph + 1;
            res[31:16] <= 16'h1;
        end
        else if (fall && ph == 3)
        begin
            ph        <= 4;
            res[15:0] <= 16'h1;
        end
        else if (ph == 3)
            res[31:16] <= res[31:16] + 16'h1;
        else if (ph == 4)
            res[15:0] <= res[15:0] + 16'h1;
    end
endmodule // gpwm_rx

// ---- verification/gpwm_top_tb.sv ----
// Purpose: self-checking bench for the pin level pwm encoder
// Assumes: clock enable and byte strobes held fully on
// Notes:   counts kept at 4 units or less to bound run time
`timescale 1ns/100ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
    mismatches++; $display("wrong value %s exp %h got %h", nm, e, g); \
    end end

module gpwm_top_tb;
    logic        clk = 1'b0, rstn = 1'b0;          // clock, reset
    logic        psel = 1'b0, penable = 1'b0;      // apb phase
    logic        pwrite = 1'b0;                    // apb direction
    logic [11:0] paddr = '0;                       // apb address
    logic [31:0] pwdata = '0, prdata;              // apb data
    logic        pready, pslverr, pin0, pin1;      // design outputs
    logic        arm = 1'b0, sel = 1'b0, dn0, dn1; // receiver control
    logic [32:0] rs0, rs1, e;                      // results, note
    logic [32:0] rq[$], mq[$];                     // expected notes
    int          mismatches = 0, check_count = 0, cyc = 0;
    gpwm_top u_gpwm_top (.clk, .rstn, .ce(1'b1), .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb(4'hF), .prdata, .pready,
        .pslverr, .general_pin_zero(pin0), .general_pin_one(pin1));
    // only the selected receiver is armed, so a stale strobe from the
    // other pin can never be taken as this measurement's result
    gpwm_rx u_gpwm_rx0 (.clk, .pin(pin0), .arm(arm && !sel),
        .done(dn0), .res(rs0));
    gpwm_rx u_gpwm_rx1 (.clk, .pin(pin1), .arm(arm && sel),
        .done(dn1), .res(rs1));
    initial forever #20 clk = ~clk;
    // ------------------------------------
    // result watcher and hang guard
    // ------------------------------------
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (psel && penable && pready && !pwrite)
        begin
            e = rq.pop_front();
            `CHK("read", e, {pslverr, prdata})
        end
        if (sel ? dn1 : dn0)
        begin
            e = mq.pop_front();
            `CHK("pin", e, sel ? rs1 : rs0)
        end
        if (cyc == 100000)
        begin
            mismatches++;  // run hung
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // one apb transfer; entered just after a rising edge
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(logic [11:0] a, logic [32:0] x);
        rq.push_back(x);
        apb(1'b0, a, 32'h0);
    endtask
    // times one cycle of a pin, or reports its static level
    task automatic meas(logic p, logic [32:0] x);
        mq.push_back(x);
        sel <= p;
        arm <= 1'b1;
        @(posedge clk);
        arm <= 1'b0;
        do @(posedge clk); while (!(p ? dn1 : dn0));
        @(posedge clk);
    endtask
    initial
    begin
        logic [6:0] hc, lc;
        void'($urandom(81171));
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(12'h13C, {1'b0, 32'h007F});
        rd(12'h140, {1'b0, 32'h3F80});
        rd(12'h144, {1'b0, 32'h007F});
        rd(12'h148, {1'b0, 32'h3F80});
        rd(12'h000, {1'b1, 32'h0});
        meas(1'b0, 33'h0);
        meas(1'b1, 33'h0);
        apb(1'b1, 12'h180, 32'h2);
        meas(1'b1, {1'b1, 32'h0});
        rd(12'h184, {1'b0, 32'h0000_000A});
        rd(12'h180, {1'b0, 32'h0000_0002});
        apb(1'b1, 12'h148, 32'hFFFF);
        rd(12'h148, {1'b0, 32'h3FFF});
        apb(1'b1, 12'h148, 32'h0);
        meas(1'b1, 33'h0);
        apb(1'b1, 12'h180, 32'h0);
        // every time base code, random phase counts
        for (int i = 0; i < 4; i++)
        begin
            hc = 7'($urandom_range(4, 1));
            lc = 7'($urandom_range(4, 1));
            apb(1'b1, 12'h144, {16'h0, 2'(i), hc, lc});
            meas(1'b1, {1'b1, 16'(hc * (16 << (2 * i))),
                16'(lc * (16 << (2 * i)))});
        end
        // pin 0: each level uses its own pair
        apb(1'b1, 12'h13C, {18'h0, 7'd2, 7'd1});
        apb(1'b1, 12'h140, {18'h3, 7'd1, 7'd3});
        rd(12'h140, {1'b0, 32'h0083});
        apb(1'b1, 12'h180, 32'h1);
        meas(1'b0, {1'b1, 32'h0010_0030});
        apb(1'b1, 12'h180, 32'h0);
        meas(1'b0, {1'b1, 32'h0020_0010});
        finish_test();
    end
endmodule // gpwm_top_tb

bind gpwm_top gpwm_chk u_gpwm_chk (.clk, .rstn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .general_pin_zero, .general_pin_one);
